// ===== smp_poller.sv
// smp_poller: serial subnetwork master that polls a table of slave nodes.
// assumes AXI4-Lite on aclk and a line transceiver outside on txd/rxd.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module smp_poller #(
   parameter int CYC_PER_MS = smp_pkg::CYC_PER_MS,
   parameter int MAX_NODES = smp_pkg::MAX_NODES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic txd,
   input wire logic rxd
);
   typedef enum logic [2:0] {P_IDLE, P_PICK, P_SEND, P_WAIT, P_NEXT} smp_state_t;
   smp_state_t state_reg;
   smp_ser_if ser ();
   logic [7:0] awa_reg;
   logic [31:0] wd_reg;
   logic [3:0] ws_reg;
   logic aw_ok_reg, w_ok_reg;
   logic wr_fire, rd_fire;
   logic [7:0] mux_addr;
   logic [31:0] rd_val, wval, mask;
   logic map_ok;
   logic [3:0] baud_reg;
   logic [1:0] par_reg;
   logic stop2_reg;
   logic [4:0] sel_reg, cnt_reg;
   logic [7:0] n_addr [MAX_NODES];
   logic [3:0] n_retry [MAX_NODES];
   logic [7:0] n_ncmd [MAX_NODES];
   logic n_bc [MAX_NODES];
   logic [13:0] n_tmo [MAX_NODES];
   logic [19:0] n_rec [MAX_NODES];
   logic [19:0] rec_left [MAX_NODES];
   logic run_reg;
   logic [2:0] stat_reg, st_set;
   logic [19:0] cmd_raw_reg;
   logic [1:0] fmt_reg;
   logic [7:0] func_reg;
   logic [7:0] free_addr;
   logic dup, addr_bad, sel_ok;
   logic [4:0] node_reg;
   logic [7:0] cmd_reg;
   logic [3:0] try_reg;
   logic [1:0] byte_reg;
   logic [13:0] tmo_reg;
   logic [15:0] ms_cnt_reg;
   logic ms_tick;
   logic [15:0] wire_base, wire_addr;
   logic [7:0] tx_data, rx_data;
   logic tx_ready, rx_valid, rx_perr, skip_set;
   logic [4:0] node_nx;
   // register bus
   assign awready = !aw_ok_reg;
   assign wready = !w_ok_reg;
   assign wr_fire = aw_ok_reg && w_ok_reg && !bvalid;
   // a read waits while a complete write is pending so one decoder serves both
   assign arready = !rvalid && !(aw_ok_reg && w_ok_reg);
   assign rd_fire = arvalid && arready;
   assign mux_addr = (aw_ok_reg && w_ok_reg) ? awa_reg : araddr;
   assign mask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
   assign wval = (rd_val & ~mask) | (wd_reg & mask);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_reg <= 1'b0;
         w_ok_reg <= 1'b0;
         awa_reg <= 8'h00;
         wd_reg <= 32'h0000_0000;
         ws_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= smp_pkg::RESP_OK;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= smp_pkg::RESP_OK;
      end else begin
         if (awvalid && awready) begin
            awa_reg <= awaddr;
            aw_ok_reg <= 1'b1;
         end
         if (wvalid && wready) begin
            wd_reg <= wdata;
            ws_reg <= wstrb;
            w_ok_reg <= 1'b1;
         end
         if (wr_fire) begin
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= map_ok ? smp_pkg::RESP_OK : smp_pkg::RESP_ERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         if (rd_fire) begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= map_ok ? smp_pkg::RESP_OK : smp_pkg::RESP_ERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
   always_comb begin
      rd_val = 32'h0000_0000;
      map_ok = 1'b1;
      unique case ({mux_addr[7:2], 2'b00})
         smp_pkg::OFF_CFG: rd_val = {25'h000_0000, stop2_reg, par_reg, baud_reg};
         smp_pkg::OFF_NSEL: rd_val = {27'h000_0000, sel_reg};
         smp_pkg::OFF_NADDR:
            rd_val = {11'h000, n_bc[sel_reg], n_ncmd[sel_reg], n_retry[sel_reg],
                      n_addr[sel_reg]};
         smp_pkg::OFF_NTMO: rd_val = {18'h0_0000, n_tmo[sel_reg]};
         smp_pkg::OFF_NREC: rd_val = {12'h000, n_rec[sel_reg]};
         smp_pkg::OFF_CTRL: rd_val = {31'h0000_0000, run_reg};
         smp_pkg::OFF_STAT:
            rd_val = {11'h000, cnt_reg, 7'h00, state_reg != P_IDLE, 5'h00, stat_reg};
         smp_pkg::OFF_CMD: rd_val = {func_reg, 2'h0, fmt_reg, cmd_raw_reg};
         default: map_ok = 1'b0;
      endcase
   end
   // character format and command register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_reg <= smp_pkg::BAUD_RST;
         par_reg <= smp_pkg::PAR_NONE;
         stop2_reg <= 1'b0;
         cmd_raw_reg <= 20'h0_0000;
         fmt_reg <= smp_pkg::FMT_ADDR;
         func_reg <= 8'h03;
      end else if (wr_fire && awa_reg[7:2] == smp_pkg::OFF_CFG[7:2]) begin
         if (32'(wval[3:0]) < smp_pkg::NUM_RATES && wval[5:4] != 2'h3) begin
            baud_reg <= wval[3:0];
            par_reg <= wval[5:4];
            stop2_reg <= wval[6];
         end
      end else if (wr_fire && awa_reg[7:2] == smp_pkg::OFF_CMD[7:2]) begin
         cmd_raw_reg <= wval[19:0];
         fmt_reg <= wval[21:20];
         func_reg <= wval[31:24];
      end
   end
   always_comb begin
      ser.div = 16'h0000;
      for (int i = 0; i < smp_pkg::NUM_RATES; i++) begin
         if (32'(baud_reg) == i) begin
            ser.div = 16'(smp_pkg::baud_div(i));
         end
      end
   end
   assign ser.par = par_reg;
   assign ser.stop2 = stop2_reg;
   // node table checks
   assign sel_ok = sel_reg < cnt_reg;
   assign addr_bad = wval[7:0] < smp_pkg::ADDR_MIN || wval[7:0] > smp_pkg::ADDR_MAX;
   always_comb begin
      logic used;
      used = 1'b0;
      dup = 1'b0;
      free_addr = 8'h00;
      for (int n = 0; n < MAX_NODES; n++) begin
         if (n < 32'(cnt_reg) && n != 32'(sel_reg) && !n_bc[n] && n_addr[n] == wval[7:0]) begin
            dup = 1'b1;
         end
      end
      // walk downward so the lowest unused address is kept
      for (int a = 32'(smp_pkg::ADDR_MAX); a >= 32'(smp_pkg::ADDR_MIN); a--) begin
         used = 1'b0;
         for (int n = 0; n < MAX_NODES; n++) begin
            if (n < 32'(cnt_reg) && 32'(n_addr[n]) == a) begin
               used = 1'b1;
            end
         end
         if (!used) begin
            free_addr = 8'(a);
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 5'h00;
         sel_reg <= 5'h00;
         run_reg <= 1'b0;
      end else if (wr_fire) begin
         unique case ({awa_reg[7:2], 2'b00})
            smp_pkg::OFF_NSEL:
               if (32'(wval[4:0]) < MAX_NODES) begin
                  sel_reg <= wval[4:0];
               end
            smp_pkg::OFF_NADDR:
               if (sel_ok && (wval[20] || (!addr_bad && !dup))
                   && 32'(wval[11:8]) <= smp_pkg::RETRY_MAX
                   && wval[19:12] != 8'h00 && 32'(wval[19:12]) <= smp_pkg::MAX_CMDS) begin
                  n_addr[sel_reg] <= wval[20] ? 8'h00 : wval[7:0];
                  n_retry[sel_reg] <= wval[11:8];
                  n_ncmd[sel_reg] <= wval[19:12];
                  n_bc[sel_reg] <= wval[20];
               end
            smp_pkg::OFF_NTMO:
               if (sel_ok && 32'(wval[13:0]) >= smp_pkg::TMO_MIN_MS
                   && 32'(wval[13:0]) <= smp_pkg::TMO_MAX_MS && wval[31:14] == 18'h0_0000) begin
                  n_tmo[sel_reg] <= wval[13:0];
               end
            smp_pkg::OFF_NREC:
               if (sel_ok && 32'(wval[19:0]) >= smp_pkg::REC_MIN_MS
                   && 32'(wval[19:0]) <= smp_pkg::REC_MAX_MS && wval[31:20] == 12'h000) begin
                  n_rec[sel_reg] <= wval[19:0];
               end
            smp_pkg::OFF_CTRL: begin
               run_reg <= wval[smp_pkg::CTRL_RUN];
               if (wval[smp_pkg::CTRL_CLR]) begin
                  cnt_reg <= 5'h00;
               end else if (wval[smp_pkg::CTRL_ADD] && 32'(cnt_reg) < MAX_NODES
                            && free_addr != 8'h00) begin
                  n_addr[cnt_reg] <= free_addr;
                  n_retry[cnt_reg] <= 4'h0;
                  n_ncmd[cnt_reg] <= 8'h01;
                  n_bc[cnt_reg] <= 1'b0;
                  n_tmo[cnt_reg] <= 14'(smp_pkg::TMO_RST_MS);
                  n_rec[cnt_reg] <= 20'(smp_pkg::REC_RST_MS);
                  cnt_reg <= cnt_reg + 5'h01;
               end
            end
            default: ;
         endcase
      end
   end
   // status, set wins over a write-one clear in the same cycle
   always_comb begin
      st_set = 3'h0;
      st_set[smp_pkg::ST_EXH] = skip_set;
      st_set[smp_pkg::ST_PAR] = rx_valid && rx_perr;
      st_set[smp_pkg::ST_REJ] = wr_fire && awa_reg[7:2] == smp_pkg::OFF_NADDR[7:2]
                                && !(wval[20] || (!addr_bad && !dup));
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_reg <= 3'h0;
      end else if (wr_fire && awa_reg[7:2] == smp_pkg::OFF_STAT[7:2]) begin
         stat_reg <= (stat_reg & ~wval[2:0]) | st_set;
      end else begin
         stat_reg <= stat_reg | st_set;
      end
   end
   // millisecond time base for timeouts and reconnection delays
   assign ms_tick = 32'(ms_cnt_reg) == CYC_PER_MS - 1;
   always_ff @(posedge aclk) begin
      if (!aresetn || ms_tick) begin
         ms_cnt_reg <= 16'h0000;
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int n = 0; n < MAX_NODES; n++) begin
            rec_left[n] <= 20'h0_0000;
         end
      end else begin
         for (int n = 0; n < MAX_NODES; n++) begin
            if (skip_set && 32'(node_reg) == n && !n_bc[n]) begin
               rec_left[n] <= n_rec[n];
            end else if (ms_tick && rec_left[n] != 20'h0_0000) begin
               rec_left[n] <= rec_left[n] - 20'h0_0001;
            end
         end
      end
   end
   // register address as it goes on the wire
   always_comb begin
      logic [19:0] v;
      v = cmd_raw_reg;
      for (int k = 1; k < 10; k++) begin
         if (fmt_reg == smp_pkg::FMT_PFX5 && 32'(cmd_raw_reg) >= k * smp_pkg::PFX5_UNIT) begin
            v = cmd_raw_reg - 20'(k * smp_pkg::PFX5_UNIT);
         end
         if (fmt_reg == smp_pkg::FMT_PFX6 && 32'(cmd_raw_reg) >= k * smp_pkg::PFX6_UNIT) begin
            v = cmd_raw_reg - 20'(k * smp_pkg::PFX6_UNIT);
         end
      end
      // numbered formats count from one; zero stays zero
      if (fmt_reg != smp_pkg::FMT_ADDR && v != 20'h0_0000) begin
         v = v - 20'h0_0001;
      end
      wire_base = v[15:0];
   end
   assign wire_addr = wire_base + {8'h00, cmd_reg};
   always_comb begin
      unique case (byte_reg)
         2'h0: tx_data = n_addr[node_reg];
         2'h1: tx_data = func_reg;
         2'h2: tx_data = wire_addr[15:8];
         2'h3: tx_data = wire_addr[7:0];
      endcase
   end
   // polling sequence
   assign node_nx = (node_reg + 5'h01 >= cnt_reg) ? 5'h00 : node_reg + 5'h01;
   assign skip_set = state_reg == P_WAIT && !n_bc[node_reg] && ms_tick
                     && tmo_reg == 14'h0000 && try_reg >= n_retry[node_reg]
                     && !(rx_valid && rx_data == n_addr[node_reg]);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= P_IDLE;
         node_reg <= 5'h00;
         cmd_reg <= 8'h00;
         try_reg <= 4'h0;
         byte_reg <= 2'h0;
         tmo_reg <= 14'h0000;
      end else begin
         unique case (state_reg)
            P_IDLE:
               if (run_reg && cnt_reg != 5'h00) begin
                  node_reg <= 5'h00;
                  state_reg <= P_PICK;
               end
            P_PICK:
               if (!run_reg || node_reg >= cnt_reg) begin
                  state_reg <= P_IDLE;
               end else if (rec_left[node_reg] == 20'h0_0000) begin
                  cmd_reg <= 8'h00;
                  try_reg <= 4'h0;
                  byte_reg <= 2'h0;
                  state_reg <= P_SEND;
               end else begin
                  node_reg <= node_nx;
               end
            P_SEND:
               if (tx_ready) begin
                  byte_reg <= byte_reg + 2'h1;
                  if (byte_reg == 2'h3) begin
                     tmo_reg <= n_tmo[node_reg];
                     state_reg <= P_WAIT;
                  end
               end
            P_WAIT:
               if (n_bc[node_reg] || (rx_valid && rx_data == n_addr[node_reg])) begin
                  state_reg <= P_NEXT;
               end else if (ms_tick) begin
                  if (tmo_reg != 14'h0000) begin
                     tmo_reg <= tmo_reg - 14'h0001;
                  end else if (try_reg < n_retry[node_reg]) begin
                     try_reg <= try_reg + 4'h1;
                     byte_reg <= 2'h0;
                     state_reg <= P_SEND;
                  end else begin
                     // later cycles skip the node while its delay runs
                     node_reg <= node_nx;
                     state_reg <= P_PICK;
                  end
               end
            P_NEXT:
               if (cmd_reg + 8'h01 >= n_ncmd[node_reg]) begin
                  node_reg <= node_nx;
                  state_reg <= P_PICK;
               end else begin
                  cmd_reg <= cmd_reg + 8'h01;
                  try_reg <= 4'h0;
                  byte_reg <= 2'h0;
                  state_reg <= P_SEND;
               end
            default: state_reg <= P_IDLE;
         endcase
      end
   end
   smp_tx u_tx (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(ser.snk),
      .data(tx_data),
      .valid(state_reg == P_SEND),
      .ready(tx_ready),
      .txd(txd)
   );
   smp_rx u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(ser.snk),
      .rxd(rxd),
      .data(rx_data),
      .valid(rx_valid),
      .perr(rx_perr)
   );
endmodule

// ===== smp_pkg.sv
// smp_pkg: constants shared by the serial master poller and its serial engines.
// assumes one 40 MHz clock domain and a 32-bit AXI4-Lite register bus.
package smp_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int NUM_RATES = 11;
   localparam int BAUD_TAB [NUM_RATES] = '{1200, 1800, 2400, 4800, 9600, 19200, 35700,
                                          38400, 57600, 115200, 128000};
   localparam logic [3:0] BAUD_RST = 4'h4;
   localparam int DIV_W = 16;
   localparam int DATA_BITS = 8;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] FMT_ADDR = 2'h0;
   localparam logic [1:0] FMT_REG = 2'h1;
   localparam logic [1:0] FMT_PFX5 = 2'h2;
   localparam logic [1:0] FMT_PFX6 = 2'h3;
   localparam int PFX5_UNIT = 10000;
   localparam int PFX6_UNIT = 100000;
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_NSEL = 8'h04;
   localparam logic [7:0] OFF_NADDR = 8'h08;
   localparam logic [7:0] OFF_NTMO = 8'h0c;
   localparam logic [7:0] OFF_NREC = 8'h10;
   localparam logic [7:0] OFF_CTRL = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h18;
   localparam logic [7:0] OFF_CMD = 8'h1c;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_ADD = 1;
   localparam int CTRL_CLR = 2;
   localparam int ST_EXH = 0;
   localparam int ST_PAR = 1;
   localparam int ST_REJ = 2;
   localparam int ST_BUSY = 8;
   localparam int MAX_NODES = 31;
   localparam int MAX_CMDS = 150;
   localparam int RETRY_MAX = 10;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hf7;
   localparam int TMO_MIN_MS = 10;
   localparam int TMO_MAX_MS = 10000;
   localparam int TMO_RST_MS = 1000;
   localparam int REC_MIN_MS = 10;
   localparam int REC_MAX_MS = 600000;
   localparam int REC_RST_MS = 10000;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   function automatic int baud_div(input int i);
      return CLK_HZ / BAUD_TAB[i];
   endfunction
endpackage

// ===== smp_ser_if.sv
// smp_ser_if: character format handed from the poller to its serial engines.
// assumes the source holds the fields steady between characters.
`timescale 1ns/1ps
interface smp_ser_if;
   logic [15:0] div;
   logic [1:0] par;
   logic stop2;
   modport src (output div, output par, output stop2);
   modport snk (input div, input par, input stop2);
endinterface

// ===== smp_tx.sv
// smp_tx: serial character transmitter, one character at a time.
// assumes cfg changes only while ready is high.
`timescale 1ns/1ps
module smp_tx (
   input wire logic aclk,
   input wire logic aresetn,
   smp_ser_if.snk cfg,
   input wire logic [7:0] data,
   input wire logic valid,
   output logic ready,
   output logic txd
);
   logic [10:0] sh_reg;
   logic [3:0] left_reg;
   logic [15:0] cnt_reg;
   logic par_en;
   logic pbit;
   assign par_en = cfg.par == smp_pkg::PAR_ODD || cfg.par == smp_pkg::PAR_EVEN;
   assign pbit = (^data) ^ (cfg.par == smp_pkg::PAR_ODD);
   assign ready = left_reg == 4'h0;
   assign txd = sh_reg[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh_reg <= 11'h7ff;
         left_reg <= 4'h0;
         cnt_reg <= 16'h0000;
      end else if (ready && valid) begin
         // start low, data lsb first, parity or stop, final stop
         sh_reg <= {1'b1, par_en ? pbit : 1'b1, data, 1'b0};
         left_reg <= 4'(10 + 32'(par_en) + 32'(cfg.stop2));
         cnt_reg <= cfg.div - 16'h0001;
      end else if (!ready) begin
         if (cnt_reg == 16'h0000) begin
            sh_reg <= {1'b1, sh_reg[10:1]};
            left_reg <= left_reg - 4'h1;
            cnt_reg <= cfg.div - 16'h0001;
         end else begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
      end
   end
endmodule

// ===== smp_rx.sv
// smp_rx: serial character receiver with parity check.
// assumes rxd is already synchronous to aclk; a low stop bit drops the character.
`timescale 1ns/1ps
module smp_rx (
   input wire logic aclk,
   input wire logic aresetn,
   smp_ser_if.snk cfg,
   input wire logic rxd,
   output logic [7:0] data,
   output logic valid,
   output logic perr
);
   logic [15:0] cnt_reg;
   logic [3:0] idx_reg;
   logic [9:0] sh_reg;
   logic busy_reg;
   logic rxd_d_reg;
   logic par_en;
   logic [3:0] nbits;
   logic [7:0] byte_w;
   assign par_en = cfg.par == smp_pkg::PAR_ODD || cfg.par == smp_pkg::PAR_EVEN;
   assign nbits = 4'(smp_pkg::DATA_BITS + 32'(par_en));
   assign byte_w = par_en ? sh_reg[8:1] : sh_reg[9:2];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_reg <= 1'b0;
         rxd_d_reg <= 1'b1;
         cnt_reg <= 16'h0000;
         idx_reg <= 4'h0;
         sh_reg <= 10'h000;
         valid <= 1'b0;
         perr <= 1'b0;
         data <= 8'h00;
      end else begin
         rxd_d_reg <= rxd;
         valid <= 1'b0;
         if (!busy_reg) begin
            if (rxd_d_reg && !rxd) begin
               busy_reg <= 1'b1;
               cnt_reg <= {1'b0, cfg.div[15:1]};
               idx_reg <= 4'h0;
            end
         end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
         end else begin
            cnt_reg <= cfg.div - 16'h0001;
            if (idx_reg == 4'h0) begin
               // a start pulse shorter than half a bit is noise
               busy_reg <= !rxd;
               idx_reg <= 4'h1;
            end else if (idx_reg <= nbits) begin
               sh_reg <= {rxd, sh_reg[9:1]};
               idx_reg <= idx_reg + 4'h1;
            end else begin
               busy_reg <= 1'b0;
               valid <= rxd;
               data <= byte_w;
               // even: data and parity xor to 0, odd: to 1
               perr <= par_en && ((^byte_w ^ sh_reg[9]) != (cfg.par == smp_pkg::PAR_ODD));
            end
         end
      end
   end
endmodule

// ===== smp_poller_checker.sv
// smp_poller_checker: handshake and line properties at the poller ports.
// assumes the poller port names; bound below.
`timescale 1ns/1ps
module smp_poller_checker (
   input wire logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
   input wire logic arvalid, arready, rvalid, rready, txd,
   input wire logic [7:0] araddr,
   input wire logic [31:0] rdata,
   input wire logic [1:0] bresp, rresp
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_TX_IDLE: assert property ($rose(aresetn) |-> txd) else $error("line busy");
   // both halves are latched first, so the answer comes one edge after that
   AST_WR_ANS: assert property (awvalid && awready && wvalid && wready && !bvalid |=> ##1 bvalid)
      else $error("no write answer");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer lost");
   AST_RD_ANS: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer lost");
   AST_AR_WAIT: assert property (rvalid |-> !arready) else $error("read taken early");
   AST_UNMAP: assert property (arvalid && arready && araddr[7:2] > 6'h07 |=> rresp == 2'h2)
      else $error("unmapped read accepted");
   AST_START: assert property ($fell(txd) |=> !txd [*8]) else $error("short low bit");
   AST_STOP: assert property ($rose(txd) |=> txd [*8]) else $error("short high bit");
   cover property (bvalid && bready);
   cover property (rvalid && rready && rresp == 2'h2);
   cover property ($fell(txd));
endmodule
bind smp_poller smp_poller_checker chk (.*);

// ===== smp_slave_model.sv
// smp_slave_model: one serial slave answering frames sent to its address.
// assumes 8N1 characters at DIV clocks per bit, four characters a frame.
`timescale 1ns/1ps
module smp_slave_model #(
   parameter int DIV = 312,
   parameter logic [7:0] ADDR = 8'h01
) (
   input wire logic aclk,
   input wire logic txd,
   input wire logic [15:0] lag,
   output logic rxd
);
   logic [9:0] frame;
   logic [7:0] ch;
   logic hit;
   int n;
   assign frame = {1'b1, ADDR, 1'b0};
   initial begin
      rxd = 1'b1;
      n = 0;
      hit = 1'b0;
      forever begin
         @(negedge txd);
         repeat (DIV + DIV / 2) @(posedge aclk);
         for (int i = 0; i < 8; i++) begin
            ch[i] = txd;
            repeat (DIV) @(posedge aclk);
         end
         n = (n + 1) % 4;
         if (n == 1) hit = (ch == ADDR);
         if (n == 0 && hit) begin
            repeat (lag) @(posedge aclk);
            for (int i = 0; i < 10; i++) begin
               rxd <= frame[i];
               // stop bit not waited out, so the next request is never missed
               if (i < 9) repeat (DIV) @(posedge aclk);
            end
         end
      end
   end
endmodule

// ===== test_serial_master_poller.sv
// test_serial_master_poller: register and polling sequences for the poller.
// assumes one slave model at address 1 and a 40-cycle millisecond.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("Error %s expected %h seen %h", what, exp, got); end end
module test_serial_master_poller;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, txd, rxd;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs, bs;
   int n_errors = 0;
   int checks_done = 0;
   smp_poller #(.CYC_PER_MS(40)) uut (.*);
   smp_slave_model #(.DIV(312), .ADDR(8'h01)) slave (.aclk(aclk), .txd(txd),
      .lag(16'h0040), .rxd(rxd));
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      logic aw_s, w_s, b_s;
      t = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      // handshakes are judged on settled values, never in the launching time step
      do begin
         @(negedge aclk);
         {aw_s, w_s, b_s} = {awvalid && awready, wvalid && wready, bvalid};
         bs = bresp;
         @(posedge aclk);
         t++;
         if (aw_s) awvalid <= 1'b0;
         if (w_s) wvalid <= 1'b0;
      end while (!b_s && t < 200);
      bready <= 1'b0;
      if (!b_s) begin
         n_errors++;
         give_verdict;
      end
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int t;
      logic ar_s, r_s;
      t = 0;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(negedge aclk);
         {ar_s, r_s} = {arvalid && arready, rvalid};
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
         t++;
         if (ar_s) arvalid <= 1'b0;
      end while (!r_s && t < 200);
      rready <= 1'b0;
      if (!r_s) begin
         n_errors++;
         give_verdict;
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(8'h00);
      `CHK("cfg", 32'h0000_0004, rd)
      wr(8'h00, 32'h0000_005a);
      wr(8'h00, 32'h0000_0030);
      rd_reg(8'h00);
      `CHK("cfg", 32'h0000_005a, rd)
      wr(8'h00, 32'h0000_000a);
      `CHK("wresp", 2'h0, bs)
      rd_reg(8'h20);
      `CHK("unmapped", 2'h2, rs)
      wr(8'h24, 32'h0000_0001);
      `CHK("wunmapped", 2'h2, bs)
      wr(8'h1c, 32'h0321_0005);
      rd_reg(8'h1c);
      `CHK("cmd", 32'h0321_0005, rd)
      wr(8'h14, 32'h0000_0002);
      wr(8'h04, 32'h0000_0000);
      rd_reg(8'h08);
      `CHK("node", 32'h0000_1001, rd)
      rd_reg(8'h10);
      `CHK("reconnect", 32'h0000_2710, rd)
      wr(8'h08, 32'h0000_1000);
      rd_reg(8'h18);
      `CHK("status", 32'h0001_0004, rd & 32'h001f_0007)
      wr(8'h18, 32'h0000_0004);
      rd_reg(8'h0c);
      `CHK("timeout", 32'h0000_03e8, rd)
      wr(8'h0c, 32'h0000_00c8);
      wr(8'h0c, 32'h0000_0009);
      rd_reg(8'h0c);
      `CHK("timeout", 32'h0000_00c8, rd)
      wr(8'h14, 32'h0000_0001);
      repeat (30000) @(posedge aclk);
      rd_reg(8'h18);
      `CHK("answered", 32'h0000_0000, rd & 32'h0000_0007)
      wr(8'h14, 32'h0000_0003);
      wr(8'h04, 32'h0000_0001);
      wr(8'h0c, 32'h0000_00c8);
      rd_reg(8'h08);
      `CHK("node", 32'h0000_1002, rd)
      wr(8'h08, 32'h0000_1001);
      rd_reg(8'h18);
      `CHK("status", 32'h0002_0004, rd & 32'h001f_0007)
      for (int i = 0; i < 400 && rd[0] !== 1'b1; i++) begin
         repeat (100) @(posedge aclk);
         rd_reg(8'h18);
      end
      `CHK("exhausted", 32'h0002_0005, rd & 32'h001f_0007)
      give_verdict;
   end
endmodule
